// >>> hdl/wfm_cmp_bit.sv
`timescale 1ns/1ps
// One identifier bit compare under its mask
module wfm_cmp_bit
(
  input  wire logic mask_bit,
  input  wire logic cfg_bit,
  input  wire logic rx_bit,
  output logic      bit_ok
);
  // Masked bit must agree, unmasked bit always agrees
  assign bit_ok = ~mask_bit | (cfg_bit == rx_bit); // RULE1 RULE2
endmodule : wfm_cmp_bit

// >>> hdl/wfm_pkg.sv
// Functional notes
// (RULE1) Mask one: identifier bit is compared
// (RULE2) Mask zero: identifier bit is ignored
// (RULE3) Mask layout 15:8 and 6:2, rest reserved
// (RULE4) Reserved bits read zero, ignore writes
// (RULE5) Length code four bits at 3:0
// (RULE6) Codes eight to fifteen mean eight bytes
// (RULE7) Code zero means zero bytes, cleared state
// (RULE8) Received code must equal configured bitwise
// (RULE9) Extension bit selects 11 or 29 bit
// (RULE10) Restart keeps fields; power-on clears all
package wfm_pkg;
  // Register addresses on the serial port
  localparam logic [6:0]  WFM_ADDR_MASK    = 7'h35;
  localparam logic [6:0]  WFM_ADDR_DLC     = 7'h36;
  // Writable field positions
  localparam int          WFM_MASK_HI_LSB  = 8;
  localparam int          WFM_MASK_LO_LSB  = 2;
  // Writable-bit masks of each register
  localparam logic [15:0] WFM_MASK_WMASK   = 16'hff7c;
  localparam logic [15:0] WFM_DLC_WMASK    = 16'h000f;
  // Reset values
  localparam logic [15:0] WFM_RESET_VAL    = 16'h0000;
  // Longest payload in bytes
  localparam logic [3:0]  WFM_MAX_BYTES    = 4'h8;

  // Register-port request
  typedef struct packed {
    logic        wr;    // Write strobe
    logic        rd;    // Read strobe
    logic [6:0]  addr;  // Register address
    logic [15:0] wdata; // Write data
  } wfm_req_t;

  // Frame fields from the matching engine
  typedef struct packed {
    logic        ide;   // Extended identifier received
    logic [12:0] id;    // Identifier bits 12..0
    logic [3:0]  dlc;   // Received length code
  } wfm_frame_t;

  // Block state
  typedef struct packed {
    logic [15:0] mask;  // Mask register image
    logic [15:0] dlc;   // Length-code register image
    logic [15:0] rdata; // Read data register
  } wfm_state_t;
endpackage : wfm_pkg

// >>> hdl/wfm_regs.sv
`timescale 1ns/1ps
module wfm_regs
(
  input  wire logic              CLOCK,
  input  wire logic              RESET,
  input  wire logic              RESTART,
  input  wire wfm_pkg::wfm_req_t REQ,
  output logic [15:0]            RDATA,
  output logic [12:0]            ID_MASK,
  output logic [3:0]             CFG_DLC,
  output logic [3:0]             CFG_BYTES,
  input  wire logic [12:0]       CFG_ID,
  input  wire logic              CFG_IDE,
  input  wire wfm_pkg::wfm_frame_t RX,
  output logic                   LOW_ID_OK,
  output logic                   DLC_OK,
  output logic                   IDE_OK
);
  wfm_pkg::wfm_state_t s_q;   // Registered state
  wfm_pkg::wfm_state_t s_d;   // Next state
  logic [12:0]         bit_ok; // Per-bit compare results

  // Next state: writes, reads, restart
  always_comb
  begin
    s_d = s_q;
    if (REQ.wr && REQ.addr == wfm_pkg::WFM_ADDR_MASK)
    begin
      // Only writable positions take data
      s_d.mask = REQ.wdata & wfm_pkg::WFM_MASK_WMASK; // RULE3 RULE4
    end
    if (REQ.wr && REQ.addr == wfm_pkg::WFM_ADDR_DLC)
    begin
      // Four-bit code, upper bits stay zero
      s_d.dlc = REQ.wdata & wfm_pkg::WFM_DLC_WMASK; // RULE5 RULE4
    end
    if (REQ.rd)
    begin
      // Decode read, unmapped reads zero
      case (REQ.addr)
        wfm_pkg::WFM_ADDR_MASK: s_d.rdata = s_q.mask & wfm_pkg::WFM_MASK_WMASK; // RULE4
        wfm_pkg::WFM_ADDR_DLC:  s_d.rdata = s_q.dlc & wfm_pkg::WFM_DLC_WMASK;   // RULE4
        default:                s_d.rdata = wfm_pkg::WFM_RESET_VAL;
      endcase
    end
    if (RESTART)
    begin
      // Restart keeps fields, scrubs reserved bits
      s_d.mask = s_q.mask & wfm_pkg::WFM_MASK_WMASK; // RULE10
      s_d.dlc  = s_q.dlc & wfm_pkg::WFM_DLC_WMASK;   // RULE10
    end
  end

  // State register, power-on reset clears all; restart does not
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      s_q <= '0; // RULE10 RULE7
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Mask vector for the matcher, bit 12 down to 0
  assign ID_MASK = {s_q.mask[15:wfm_pkg::WFM_MASK_HI_LSB],
                    s_q.mask[6:wfm_pkg::WFM_MASK_LO_LSB]}; // RULE3
  assign CFG_DLC   = s_q.dlc[3:0]; // RULE5
  // Payload bytes implied by the code
  assign CFG_BYTES = s_q.dlc[3] ? wfm_pkg::WFM_MAX_BYTES : s_q.dlc[3:0]; // RULE6 RULE7
  assign RDATA     = s_q.rdata;

  // One compare cell per identifier bit
  genvar g;
  generate
    for (g = 0; g < 13; g++)
    begin : g_cmp
      wfm_cmp_bit u_bit
      (
        .mask_bit (ID_MASK[g]),
        .cfg_bit  (CFG_ID[g]),
        .rx_bit   (RX.id[g]),
        .bit_ok   (bit_ok[g])
      );
    end
  endgenerate

  assign LOW_ID_OK = &bit_ok;                 // RULE1 RULE2
  assign DLC_OK    = (RX.dlc == s_q.dlc[3:0]); // RULE8
  assign IDE_OK    = (RX.ide == CFG_IDE);      // RULE9

  // Checks on the register side
  // Request shapes are named sequences so that write, read
  // and restart-write steps read alike in the seven properties that use them

  // Accepted write to the mask register
  sequence seq_mask_wr;
    REQ.wr && REQ.addr == wfm_pkg::WFM_ADDR_MASK && !RESTART;
  endsequence

  // Accepted write to the length-code register
  sequence seq_dlc_wr;
    REQ.wr && REQ.addr == wfm_pkg::WFM_ADDR_DLC && !RESTART;
  endsequence

  // Any write that meets a restart
  sequence seq_restart_wr;
    RESTART && REQ.wr;
  endsequence

  // Read of the mask register
  sequence seq_mask_rd;
    REQ.rd && REQ.addr == wfm_pkg::WFM_ADDR_MASK;
  endsequence

  // Read of the length-code register
  sequence seq_dlc_rd;
    REQ.rd && REQ.addr == wfm_pkg::WFM_ADDR_DLC;
  endsequence

  // Written mask keeps only writable positions
  a_mask_write: assert property (@(posedge CLOCK) disable iff (RESET) // RULE3
    seq_mask_wr |=> s_q.mask == ($past(REQ.wdata) & wfm_pkg::WFM_MASK_WMASK))
    else $error("mask write wrong");

  // Upper byte lands on identifier bits 12 to 5
  a_mask_hi_map: assert property (@(posedge CLOCK) disable iff (RESET) // RULE3
    seq_mask_wr |=> ID_MASK[12:5] == $past(REQ.wdata[15:8]))
    else $error("mask upper layout wrong");

  // Bits 6 to 2 land on identifier bits 4 to 0
  a_mask_lo_map: assert property (@(posedge CLOCK) disable iff (RESET) // RULE3
    seq_mask_wr |=> ID_MASK[4:0] == $past(REQ.wdata[6:2]))
    else $error("mask lower layout wrong");

  // Reserved positions never hold a one
  a_resv_zero: assert property (@(posedge CLOCK) disable iff (RESET) // RULE4
    s_q.mask[7] == 1'b0 && s_q.mask[1:0] == 2'b00 && s_q.dlc[15:4] == 12'h000)
    else $error("reserved bit set");

  // Mask read rebuilds the word with zero holes
  a_mask_read: assert property (@(posedge CLOCK) disable iff (RESET) // RULE4
    seq_mask_rd |=> RDATA == {$past(ID_MASK[12:5]), 1'b0, $past(ID_MASK[4:0]), 2'b00})
    else $error("mask read wrong");

  // Code read shows zeros above the field
  a_dlc_read: assert property (@(posedge CLOCK) disable iff (RESET) // RULE4
    seq_dlc_rd |=> RDATA == {12'h000, $past(CFG_DLC)})
    else $error("length code read wrong");

  // Written code appears on the next cycle
  a_dlc_write: assert property (@(posedge CLOCK) disable iff (RESET) // RULE5
    seq_dlc_wr |=> CFG_DLC == $past(REQ.wdata[3:0]))
    else $error("length code write wrong");

  // Codes below eight give that many bytes
  a_bytes_low: assert property (@(posedge CLOCK) disable iff (RESET) // RULE5
    CFG_DLC < 4'h8 |-> CFG_BYTES == CFG_DLC)
    else $error("short code byte count wrong");

  // Codes eight and up give eight bytes
  a_bytes_cap: assert property (@(posedge CLOCK) disable iff (RESET) // RULE6
    CFG_DLC >= 4'h8 |-> CFG_BYTES == 4'h8)
    else $error("long code not eight bytes");

  // Payload never exceeds eight bytes
  a_bytes_max: assert property (@(posedge CLOCK) disable iff (RESET) // RULE6
    CFG_BYTES <= wfm_pkg::WFM_MAX_BYTES)
    else $error("payload above eight bytes");

  // Zero code means an empty payload
  a_bytes_zero: assert property (@(posedge CLOCK) disable iff (RESET) // RULE7
    CFG_DLC == 4'h0 |-> CFG_BYTES == 4'h0)
    else $error("zero code not zero bytes");

  // A code match needs every bit equal
  a_dlc_exact: assert property (@(posedge CLOCK) disable iff (RESET) // RULE8
    DLC_OK |-> RX.dlc == CFG_DLC)
    else $error("length code match loose");

  // Equal codes always match
  a_dlc_match: assert property (@(posedge CLOCK) disable iff (RESET) // RULE8
    RX.dlc == CFG_DLC |-> DLC_OK)
    else $error("equal length codes missed");

  // Two eight-byte codes that differ do not match
  a_dlc_long_ne: assert property (@(posedge CLOCK) disable iff (RESET) // RULE8
    RX.dlc[3] && CFG_DLC[3] && RX.dlc != CFG_DLC |-> !DLC_OK)
    else $error("byte count matched instead of code");

  // Empty mask lets any identifier through
  a_unmask_any: assert property (@(posedge CLOCK) disable iff (RESET) // RULE2
    ID_MASK == 13'h0000 |-> LOW_ID_OK)
    else $error("unmasked bits compared");

  // Differences only on unmasked bits still match
  a_mask_match: assert property (@(posedge CLOCK) disable iff (RESET) // RULE2
    ((CFG_ID ^ RX.id) & ID_MASK) == 13'h0000 |-> LOW_ID_OK)
    else $error("ignored bit blocked match");

  // A match means every masked bit agrees
  a_mask_cmp: assert property (@(posedge CLOCK) disable iff (RESET) // RULE1
    LOW_ID_OK |-> ((CFG_ID ^ RX.id) & ID_MASK) == 13'h0000)
    else $error("masked bit mismatch passed");

  // Extension match needs equal extension bits
  a_ide_sel: assert property (@(posedge CLOCK) disable iff (RESET) // RULE9
    IDE_OK |-> RX.ide == CFG_IDE)
    else $error("identifier length mismatch");

  // Equal extension bits always match
  a_ide_match: assert property (@(posedge CLOCK) disable iff (RESET) // RULE9
    RX.ide == CFG_IDE |-> IDE_OK)
    else $error("identifier length match missed");

  // Restart keeps mask and code as they were
  a_restart_hold: assert property (@(posedge CLOCK) disable iff (RESET) // RULE10
    RESTART |=> CFG_DLC == $past(CFG_DLC) && ID_MASK == $past(ID_MASK))
    else $error("restart lost fields");

  // A write during restart changes nothing
  a_restart_nowr: assert property (@(posedge CLOCK) disable iff (RESET) // RULE10
    seq_restart_wr |=> $stable(s_q.mask) && $stable(s_q.dlc))
    else $error("write taken during restart");

  // Reset clears both register images
  a_reset_clear: assert property (@(posedge CLOCK) // RULE10
    RESET |=> s_q.mask == 16'h0000 && s_q.dlc == 16'h0000)
    else $error("reset did not clear");

  // Reset leaves read data and payload at zero
  a_reset_rdata: assert property (@(posedge CLOCK) // RULE7
    RESET |=> RDATA == 16'h0000 && CFG_BYTES == 4'h0)
    else $error("reset left outputs set");
endmodule : wfm_regs

// >>> sim/tb_top.sv
`timescale 1ns/1ps
// Compare and count
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top;
  localparam logic [6:0] AM = wfm_pkg::WFM_ADDR_MASK; // Mask address
  localparam logic [6:0] AD = wfm_pkg::WFM_ADDR_DLC;  // Code address
  logic                clock, reset, restart, cfg_ide, send, low_ok, dlc_ok, ide_ok;
  logic [12:0]         cfg_id, id_mask;
  logic [17:0]         fields;
  logic [15:0]         rdata, rd_val;
  logic [3:0]          cfg_dlc, cfg_bytes;
  wfm_pkg::wfm_req_t   req;
  wfm_pkg::wfm_frame_t rx;
  int                  n_errors = 0;
  int                  n_tests = 0;
  wfm_regs i_wfm_regs (.CLOCK(clock), .RESET(reset), .RESTART(restart), .REQ(req), .RDATA(rdata),
    .ID_MASK(id_mask), .CFG_DLC(cfg_dlc), .CFG_BYTES(cfg_bytes), .CFG_ID(cfg_id), .CFG_IDE(cfg_ide),
    .RX(rx), .LOW_ID_OK(low_ok), .DLC_OK(dlc_ok), .IDE_OK(ide_ok));
  wfm_frame_src i_wfm_frame_src (.CLOCK(clock), .SEND(send), .FIELDS(fields), .RX(rx));
  // One register write
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge clock) req = '{1'b1, 1'b0, a, d};
    @(negedge clock) req.wr = 1'b0;
  endtask : wr
  // One register read
  task automatic rd(input logic [6:0] a);
    @(negedge clock) req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clock) req.rd = 1'b0;
    rd_val = rdata;
  endtask : rd
  // Put a frame on the bus and let it settle
  task automatic frm(input logic [17:0] f);
    @(negedge clock) fields <= f;
    send <= 1'b1;
    repeat (2) @(negedge clock);
    #1;
  endtask : frm
  // Field layout and reserved bits
  task automatic t_map;
    wr(AM, 16'hffff);
    `CHK("id_mask", 13'h1fff, id_mask)
    rd(AM);
    `CHK("mask_rd", 16'hff7c, rd_val)
    wr(AM, 16'h00a8);
    `CHK("mask_lo", 13'h000a, id_mask)
    wr(AD, 16'hfff5);
    rd(AD);
    `CHK("dlc_rd", 16'h0005, rd_val)
  endtask : t_map
  // Masked identifier and extension compare
  task automatic t_cmp;
    wr(AM, 16'h8004);
    cfg_id = 13'h1001;
    cfg_ide = 1'b1;
    frm({1'b1, 13'h1ffd, 4'h0});
    `CHK("id_ign", 1'b1, low_ok)
    `CHK("ide_eq", 1'b1, ide_ok)
    frm({1'b0, 13'h1000, 4'h0});
    `CHK("id_cmp", 1'b0, low_ok)
    `CHK("ide_ne", 1'b0, ide_ok)
  endtask : t_cmp
  // Every length code
  task automatic t_dlc;
    for (int c = 0; c < 16; c++)
    begin
      wr(AD, 16'(c));
      frm({14'h0000, 4'(c) ^ 4'h1});
      `CHK("bytes", (c > 7) ? 4'h8 : 4'(c), cfg_bytes)
      `CHK("cfg_dlc", 4'(c), cfg_dlc)
      `CHK("dlc_ne", 1'b0, dlc_ok)
      frm({14'h0000, 4'(c)});
      `CHK("dlc_eq", 1'b1, dlc_ok)
    end
  endtask : t_dlc
  // Restart holds fields, reset clears them
  task automatic t_rst;
    wr(AM, 16'h0104);
    @(negedge clock) restart = 1'b1;
    wr(AM, 16'hffff);
    @(negedge clock) restart = 1'b0;
    `CHK("restart", 13'h0021, id_mask)
    `CHK("restart_dlc", 4'hf, cfg_dlc)
    @(negedge clock) reset = 1'b1;
    @(negedge clock) reset = 1'b0;
    rd(AD);
    `CHK("dlc_clr", 16'h0000, rd_val)
    `CHK("mask_clr", 13'h0000, id_mask)
  endtask : t_rst
  // Verdict and end of run
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Watchdog
  initial
  begin
    #50000;
    n_errors++;
    stop_test();
  end
  // Main sequence
  initial
  begin
    {reset, restart, cfg_ide, send, cfg_id, fields} = {1'b1, 34'h0};
    req = '0;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    t_map();
    t_cmp();
    t_dlc();
    t_rst();
    stop_test();
  end
endmodule : tb_top

// >>> sim/wfm_frame_src.sv
`timescale 1ns/1ps
// Bus node that hands frame fields to the filter
module wfm_frame_src
(
  input  wire logic          CLOCK,
  input  wire logic          SEND,
  input  wire logic [17:0]   FIELDS,
  output wfm_pkg::wfm_frame_t RX
);
  // Fields change at falling edge; the idle bus reads recessive ones
  always @(negedge CLOCK)
    RX <= SEND ? wfm_pkg::wfm_frame_t'(FIELDS) : '1;
endmodule : wfm_frame_src
